// ==== spi_fmt_pkg.sv ====
// constants for the spi format and idle-select block
package spi_fmt_pkg;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_W = 20;
	// register word indices, byte address = index * 4
	localparam logic [2:0] IDX_IDLE = 3'h0;
	localparam logic [2:0] IDX_FMT0 = 3'h1;
	localparam logic [2:0] IDX_FMT3 = 3'h4;
	localparam logic [2:0] IDX_TXDATA = 3'h5;
	localparam logic [2:0] IDX_RXBUF = 3'h6;
	localparam logic [2:0] IDX_STATUS = 3'h7;
	// transfer_format fields
	localparam int FMT_ORDER_BIT = 20;
	localparam int FMT_IDLE_BIT = 17;
	localparam int FMT_PHASE_BIT = 16;
	localparam int FMT_DIV_LSB = 8;
	localparam int FMT_DIV_MSB = 15;
	localparam int FMT_LEN_MSB = 4;
	localparam logic [31:0] FMT_WMASK = 32'h0013_FF1F;
	localparam logic [31:0] FMT_RST = 32'h0000_0210;
	localparam logic [1:0] IDLE_RST = 2'h3;
	// transmit word fields
	localparam int TX_SEL_LSB = 16;
	localparam int TX_CS_LSB = 18;
	// status bits
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_FULL_BIT = 1;
	localparam int ST_EMPTY_BIT = 2;
	localparam int ST_RXV_BIT = 3;
	typedef enum logic [1:0] {X_IDLE, X_SETUP, X_SHIFT, X_DONE} xfer_state_e;
endpackage

// ==== spi_fmt_select.sv ====
// transmit fifo and spi master with idle select and four word formats
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	wire push = ce & in_valid & in_ready;
	wire pop = ce & out_valid & out_ready;

	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign in_ready = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) | (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
	assign out_data = mem[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - idle: select output 1 follows idle-pattern bit 1
// - idle: select output 0 follows idle-pattern bit 0
// - idle-pattern bits 31-2 read zero, writes ignored
// - format bit 20: 0 msb first, 1 lsb first
// - format bit 17 sets serial clock idle level
// - phase 0: launch on first edge, capture on second
// - phase 1: bit out before first edge, captured on first edge
// - serial clock rate is clock over divider field plus one
// - word-length codes 2h to 10h give 2 to 16 bits
// - four independent format registers 0 to 3
// - short words land right-justified in the receive buffer
module spi_fmt_select
	import spi_fmt_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic SPI_CLK_OUT,
	output logic SPI_DATA_OUT,
	input wire logic SPI_DATA_IN,
	output logic SLAVE_SELECT_OUT0,
	output logic SLAVE_SELECT_OUT1,
	output logic TRANSFER_ACTIVE,
	output logic [1:0] FORMAT_ACTIVE
);
	// position of bit idx within a word of len bits
	function automatic logic [3:0] bit_pos(input logic [4:0] idx, input logic [4:0] len, input logic lsb);
		logic [4:0] p;
		p = lsb ? idx : 5'(len - idx - 5'h01);
		return p[3:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// bus slave
	logic [1:0] idle_reg;
	logic [31:0] fmt_regs [4];
	logic dph_valid_reg;
	logic dph_write_reg;
	logic [2:0] dph_idx_reg;
	logic [31:0] hrdata_reg;
	logic [DATA_W-1:0] rxbuf_reg;
	logic rxv_reg;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [FIFO_W-1:0] fifo_out_data;
	xfer_state_e state_reg;

	wire addr_in_map = (HADDR[31:5] == 27'h0) & (HADDR[1:0] == 2'h0);
	wire [2:0] a_idx = HADDR[4:2];
	wire accept = CE & HSEL & HTRANS[1] & HREADY;
	wire rd_accept = accept & ~HWRITE & addr_in_map;
	wire dph_wr = dph_valid_reg & dph_write_reg;
	wire tx_hit = dph_wr & (dph_idx_reg == IDX_TXDATA);
	wire stall = tx_hit & ~fifo_in_ready;
	wire commit = CE & dph_wr & ~stall;
	wire is_fmt_a = (a_idx >= IDX_FMT0) & (a_idx <= IDX_FMT3);
	wire [1:0] fmt_a = 2'(a_idx - IDX_FMT0);
	wire is_fmt_d = (dph_idx_reg >= IDX_FMT0) & (dph_idx_reg <= IDX_FMT3);
	wire [1:0] fmt_d = 2'(dph_idx_reg - IDX_FMT0);
	wire busy = state_reg != X_IDLE;
	wire [31:0] status_word = {28'h0, rxv_reg, ~fifo_out_valid, ~fifo_in_ready, busy};
	wire [31:0] rd_word = (a_idx == IDX_IDLE) ? {30'h0, idle_reg} :
		is_fmt_a ? fmt_regs[fmt_a] :
		(a_idx == IDX_RXBUF) ? {16'h0, rxbuf_reg} :
		(a_idx == IDX_STATUS) ? status_word : 32'h0;
	wire rx_clear = rd_accept & (a_idx == IDX_RXBUF);

	assign HREADYOUT = CE & ~stall;
	assign HRESP = 1'b0;
	assign HRDATA = hrdata_reg;

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			dph_valid_reg <= 1'b0;
			dph_write_reg <= 1'b0;
			dph_idx_reg <= 3'h0;
			hrdata_reg <= 32'h0;
		end
		else if (CE & ~stall)
		begin
			dph_valid_reg <= accept & addr_in_map;
			dph_write_reg <= HWRITE;
			dph_idx_reg <= a_idx;
			if (accept & ~HWRITE)
				hrdata_reg <= addr_in_map ? rd_word : 32'h0;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			idle_reg <= IDLE_RST;
			for (int i = 0; i < 4; i++)
				fmt_regs[i] <= FMT_RST;
		end
		else if (commit)
		begin
			if (dph_idx_reg == IDX_IDLE)
				idle_reg <= HWDATA[1:0];
			if (is_fmt_d)
				fmt_regs[fmt_d] <= HWDATA & FMT_WMASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit fifo: transmit-data writes stall while it is full
	word_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) tx_fifo (
		.clk(SYS_CLK),
		.rst(RST),
		.ce(CE),
		.in_valid(tx_hit),
		.in_ready(fifo_in_ready),
		.in_data(HWDATA[FIFO_W-1:0]),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// shift engine
	logic [31:0] cur_fmt_reg;
	logic [DATA_W-1:0] data_reg;
	logic [DATA_W-1:0] rx_reg;
	logic [1:0] cs_reg;
	logic [1:0] fsel_reg;
	logic [7:0] cnt_reg;
	logic [4:0] idx_reg;
	logic sclk_reg;
	logic mosi_reg;
	logic [1:0] ss_reg;

	wire [1:0] new_sel = fifo_out_data[TX_SEL_LSB+1:TX_SEL_LSB];
	wire [7:0] div = cur_fmt_reg[FMT_DIV_MSB:FMT_DIV_LSB];
	wire [7:0] half = 8'((9'(div) + 9'h001) >> 1);
	wire [4:0] len = cur_fmt_reg[FMT_LEN_MSB:0];
	wire lsb_first = cur_fmt_reg[FMT_ORDER_BIT];
	wire phase = cur_fmt_reg[FMT_PHASE_BIT];
	wire clk_idle = cur_fmt_reg[FMT_IDLE_BIT];
	wire in_shift = state_reg == X_SHIFT;
	wire lead = in_shift & (cnt_reg == 8'h00);
	wire trail = in_shift & (cnt_reg == half);
	wire last_cnt = in_shift & (cnt_reg == div);
	wire last_bit = idx_reg == 5'(len - 5'h01);
	wire start = CE & fifo_out_valid & (state_reg == X_IDLE);
	wire tx_bit = data_reg[bit_pos(idx_reg, len, lsb_first)];
	wire tx_next_bit = data_reg[bit_pos(5'(idx_reg + 5'h01), len, lsb_first)];
	wire cap_now = phase ? lead : trail;
	wire done = state_reg == X_DONE;

	assign fifo_out_ready = state_reg == X_IDLE;
	assign SPI_CLK_OUT = sclk_reg;
	assign SPI_DATA_OUT = mosi_reg;
	assign SLAVE_SELECT_OUT0 = ss_reg[0];
	assign SLAVE_SELECT_OUT1 = ss_reg[1];
	assign TRANSFER_ACTIVE = busy;
	assign FORMAT_ACTIVE = fsel_reg;

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			state_reg <= X_IDLE;
		else if (CE)
		begin
			unique case (state_reg)
				X_IDLE: if (fifo_out_valid) state_reg <= X_SETUP;
				X_SETUP: state_reg <= X_SHIFT;
				X_SHIFT: if (last_cnt & last_bit) state_reg <= X_DONE;
				X_DONE: state_reg <= X_IDLE;
			endcase
		end
	end

	// format, word and select pattern latched once per transfer
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			cur_fmt_reg <= FMT_RST;
			data_reg <= 16'h0000;
			cs_reg <= IDLE_RST;
			fsel_reg <= 2'h0;
		end
		else if (start)
		begin
			cur_fmt_reg <= fmt_regs[new_sel];
			data_reg <= fifo_out_data[DATA_W-1:0];
			cs_reg <= fifo_out_data[TX_CS_LSB+1:TX_CS_LSB];
			fsel_reg <= new_sel;
		end
	end

	// divider: one serial period is div+1 clocks
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			cnt_reg <= 8'h00;
			idx_reg <= 5'h00;
		end
		else if (CE)
		begin
			if (~in_shift | last_cnt)
				cnt_reg <= 8'h00;
			else
				cnt_reg <= cnt_reg + 8'h01;
			if (~in_shift)
				idx_reg <= 5'h00;
			else if (last_cnt)
				idx_reg <= idx_reg + 5'h01;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			sclk_reg <= FMT_RST[FMT_IDLE_BIT];
		else if (CE)
		begin
			if (lead)
				sclk_reg <= ~clk_idle;
			else if (trail | ~in_shift)
				sclk_reg <= clk_idle;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			mosi_reg <= 1'b0;
		else if (CE)
		begin
			if (state_reg == X_SETUP & phase)
				mosi_reg <= tx_bit;
			else if (lead & ~phase)
				mosi_reg <= tx_bit;
			else if (trail & phase & ~last_bit)
				mosi_reg <= tx_next_bit;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			rx_reg <= 16'h0000;
		else if (CE)
		begin
			if (state_reg == X_SETUP)
				rx_reg <= 16'h0000;
			else if (cap_now)
				rx_reg[bit_pos(idx_reg, len, lsb_first)] <= SPI_DATA_IN;
		end
	end

	// registered selects switch once, straight to the idle pattern
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			ss_reg <= IDLE_RST;
		else if (CE)
		begin
			if (state_reg == X_SETUP)
				ss_reg <= cs_reg;
			else if (done | state_reg == X_IDLE)
				ss_reg <= idle_reg;
		end
	end

	// receive buffer: a new word wins over a clearing read
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			rxbuf_reg <= 16'h0000;
			rxv_reg <= 1'b0;
		end
		else if (CE)
		begin
			if (done)
			begin
				rxbuf_reg <= rx_reg;
				rxv_reg <= 1'b1;
			end
			else if (rx_clear)
				rxv_reg <= 1'b0;
		end
	end
endmodule

// ==== spi_fmt_select_properties.sv ====
// checker for the spi format and idle-select block
`timescale 1ns/100ps
module spi_fmt_select_properties (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic SPI_CLK_OUT,
	input wire logic SLAVE_SELECT_OUT0,
	input wire logic SLAVE_SELECT_OUT1,
	input wire logic TRANSFER_ACTIVE,
	input wire logic [1:0] FORMAT_ACTIVE
);
	logic tk;
	logic wr_q;
	logic rd_q;
	logic [1:0] idle_q;
	// idle register access taken on the bus
	assign tk = HSEL && HTRANS[1] && HREADY && CE && HADDR == 32'h0;
	always_ff @(posedge SYS_CLK or posedge RST)
		if (RST)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			idle_q <= 2'h3;
		end
		else if (CE)
		begin
			wr_q <= tk && HWRITE;
			rd_q <= tk && !HWRITE;
			if (wr_q)
				idle_q <= HWDATA[1:0];
		end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	a_sel0_idle: assert property (!TRANSFER_ACTIVE && $stable(idle_q) |-> SLAVE_SELECT_OUT0 == idle_q[0])
		else $error("select 0 off idle level");
	a_sel1_idle: assert property (!TRANSFER_ACTIVE && $stable(idle_q) |-> SLAVE_SELECT_OUT1 == idle_q[1])
		else $error("select 1 off idle level");
	a_clk_still: assert property (!TRANSFER_ACTIVE && !$past(TRANSFER_ACTIVE) |-> $stable(SPI_CLK_OUT))
		else $error("serial clock moved outside transfer");
	a_fmt_hold: assert property (TRANSFER_ACTIVE && $past(TRANSFER_ACTIVE) |-> $stable(FORMAT_ACTIVE))
		else $error("format changed in transfer");
	a_idle_upper: assert property (rd_q |-> HRDATA[31:2] == 30'h0)
		else $error("idle register upper bits set");
	a_resp_okay: assert property (HRESP == 1'b0)
		else $error("response not okay");
	a_ce_stall: assert property (!CE |-> !HREADYOUT)
		else $error("ready while clock disabled");
	a_wait_bound: assert property (CE && !HREADYOUT |-> ##[1:300] HREADYOUT)
		else $error("bus wait too long");
	c_fmt3: cover property (TRANSFER_ACTIVE && FORMAT_ACTIVE == 2'h3);
	c_stall: cover property (CE && !HREADYOUT);
	c_idle_rd: cover property (rd_q);
endmodule

// ==== spi_slave_model.sv ====
// serial slave that answers ones while selected
`timescale 1ns/100ps
module spi_slave_model (
	input wire logic clk,
	input wire logic sel_n,
	output logic miso
);
	logic flip = 1'b0;
	always @(posedge clk)
		flip <= !flip;
	// released line toggles so no stale level passes for data
	assign miso = sel_n ? flip : 1'b1;
endmodule

// ==== test_spi_fmt_select.sv ====
// self-checking bench for the spi format and idle-select block
`timescale 1ns/100ps
module test_spi_fmt_select;
	import spi_fmt_pkg::*;
	logic SYS_CLK, RST, CE, HSEL, HWRITE, SPI_CLK_OUT, SPI_DATA_OUT, SPI_DATA_IN;
	logic HREADYOUT, HRESP, SLAVE_SELECT_OUT0, SLAVE_SELECT_OUT1, TRANSFER_ACTIVE;
	logic [31:0] HADDR, HWDATA, HRDATA, r;
	logic [1:0] HTRANS, FORMAT_ACTIVE;
	logic [2:0] HSIZE;
	wire logic HREADY;
	int n_mismatch = 0;
	int samples_checked = 0;
	int t;
	assign HREADY = HREADYOUT;
	spi_fmt_select dut (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .SPI_CLK_OUT(SPI_CLK_OUT), .SPI_DATA_OUT(SPI_DATA_OUT),
		.SPI_DATA_IN(SPI_DATA_IN), .SLAVE_SELECT_OUT0(SLAVE_SELECT_OUT0), .SLAVE_SELECT_OUT1(SLAVE_SELECT_OUT1),
		.TRANSFER_ACTIVE(TRANSFER_ACTIVE), .FORMAT_ACTIVE(FORMAT_ACTIVE));
	spi_slave_model partner (.clk(SYS_CLK), .sel_n(SLAVE_SELECT_OUT0), .miso(SPI_DATA_IN));
	always #50 SYS_CLK = !SYS_CLK;
	////////////////////////////////////////////////////////////////////////////////
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		@(posedge SYS_CLK);
		while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		@(posedge SYS_CLK);
		while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
		q = HRDATA;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	task xfer(input logic [1:0] f, input logic [31:0] fv, input logic [15:0] d);
		logic [15:0] cap, ex;
		logic pc, lv;
		int n, len, per;
		len = fv[4:0];
		lv = fv[17] ^ fv[16];
		n = 0;
		per = 0;
		t = 0;
		cap = 16'h0;
		ex = 16'h0;
		for (int k = 0; k < len; k++)
			ex = {ex[14:0], fv[20] ? d[k] : d[len-1-k]};
		bus(1'b1, 32'({IDX_FMT0 + 3'(f), 2'b00}), fv, r);
		bus(1'b1, 32'({IDX_TXDATA, 2'b00}), {14'h0, f, d}, r);
		while (TRANSFER_ACTIVE !== 1'b1 && t < 50) begin @(negedge SYS_CLK); t++; end
		chk(FORMAT_ACTIVE, f);
		// new idle level shows once the selects go active
		@(negedge SYS_CLK);
		t++;
		chk(SPI_CLK_OUT, fv[17]);
		pc = SPI_CLK_OUT;
		while (TRANSFER_ACTIVE === 1'b1 && t < 2000)
		begin
			@(negedge SYS_CLK);
			t++;
			per++;
			// capture edge: trailing for no delay, leading for half delay
			if (SPI_CLK_OUT !== pc && SPI_CLK_OUT === lv)
			begin
				if (n == 1) chk(per, fv[15:8] + 1);
				cap = {cap[14:0], SPI_DATA_OUT};
				n++;
				per = 0;
			end
			pc = SPI_CLK_OUT;
		end
		chk(n, len);
		chk(cap, ex);
		chk(SPI_CLK_OUT, fv[17]);
		chk(SLAVE_SELECT_OUT0, 1'b1);
		rd(32'({IDX_RXBUF, 2'b00}), (32'h1 << len) - 1);
		$display("format %0d test done", f);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#3000000;
		n_mismatch++;
		end_of_test;
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		SYS_CLK = 0;
		RST = 1;
		CE = 1;
		HSEL = 0;
		HADDR = 0;
		HTRANS = 0;
		HWRITE = 0;
		HSIZE = 3'h2;
		HWDATA = 0;
		repeat (3) @(posedge SYS_CLK);
		RST <= 0;
		@(posedge SYS_CLK);
		rd(32'h0, 32'h3);
		for (int i = 1; i < 5; i++) rd(32'(i * 4), FMT_RST);
		bus(1'b1, 32'h0, 32'hFFFF_FFFD, r);
		rd(32'h0, 32'h1);
		chk(SLAVE_SELECT_OUT0, 1'b1);
		chk(SLAVE_SELECT_OUT1, 1'b0);
		rd(32'h20, 32'h0);
		CE <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
		chk(HREADYOUT, 1'b0);
		CE <= 1'b1;
		$display("register test done");
		xfer(2'h0, 32'h0000_0202, 16'h0001);
		xfer(2'h1, 32'h0012_0310, 16'hA5C3);
		xfer(2'h2, 32'h0001_0407, 16'h0059);
		xfer(2'h3, 32'h0013_0209, 16'h0135);
		rd(32'h4, 32'h0000_0202);
		rd(32'h10, 32'h0013_0209);
		// slow 16-bit format so the fifo fills and the last write stalls
		bus(1'b1, 32'h4, 32'h0000_0310, r);
		for (int i = 0; i < 18; i++) bus(1'b1, 32'h14, 32'h0, r);
		bus(1'b0, 32'h1C, 32'h0, r);
		chk(r[ST_FULL_BIT], 1'b1);
		t = 0;
		do
		begin
			bus(1'b0, 32'h1C, 32'h0, r);
			t++;
		end
		while ((r[ST_BUSY_BIT] !== 1'b0 || r[ST_EMPTY_BIT] !== 1'b1) && t < 2000);
		chk(r, 32'hC);
		$display("fifo test done");
		end_of_test;
	end
endmodule
bind spi_fmt_select spi_fmt_select_properties props (.*);
